// >>> cfg_port_pkg.sv
`default_nettype none

// ****************************************************************
// shared constants of the serial configuration port
// ****************************************************************
package cfg_port_pkg;

  // word framing, counted in shift-clock rising edges
  localparam int WORD_BITS = 24;
  localparam logic [4:0] CNT_ZERO = 5'h00;
  localparam logic [4:0] CNT_ONE = 5'h01;
  localparam logic [4:0] CNT_ADDR_DONE = 5'h0F;
  localparam logic [4:0] CNT_DATA_FIRST = 5'h10;
  localparam logic [4:0] CNT_LAST = 5'h17;

  // field positions in the assembled word
  localparam int RW_POS = 23;
  localparam int ADDR_HI = 19;
  localparam int ADDR_LO = 8;
  localparam int DATA_HI = 7;
  localparam int DATA_LO = 0;
  // positions once only the first 16 bits, read/write bit through 12-bit address, have arrived
  localparam int RW_POS_EARLY = 15;
  localparam int ADDR_HI_EARLY = 11;
  localparam int ADDR_LO_EARLY = 0;

  // register file
  localparam int REG_COUNT = 8;
  localparam int REG_IDX_W = 3;
  localparam logic [11:0] REG_COUNT_ADDR = 12'h008;
  localparam logic [11:0] REG_SOFT_RESET = 12'h000;
  localparam logic [11:0] REG_POWER = 12'h001;
  localparam logic [11:0] REG_INTERFACE = 12'h002;
  localparam logic [11:0] REG_FORMAT = 12'h003;
  localparam logic [11:0] REG_DECIMATION = 12'h004;
  localparam logic [11:0] REG_AUTOZERO = 12'h005;
  localparam logic [11:0] REG_INPUTS = 12'h006;
  localparam logic [7:0] REG_DEFAULT = 8'h00;
  localparam logic [7:0] READ_EMPTY = 8'h00;

  // field bits
  localparam int SOFT_RESET_BIT = 0;
  localparam int PD_GLOBAL_BIT = 0;
  localparam int REF_INTERNAL_BIT = 1;
  localparam int IF_SEL_HI = 1;
  localparam int IF_SEL_LO = 0;
  localparam int OFFSET_BIN_BIT = 0;
  localparam int DECIM_EN_BIT = 0;
  localparam int AUTOZERO_BIT = 0;
  localparam int CLK_SE_BIT = 0;
  localparam int INPUT_SE_BIT = 1;

  // sampling-clock presence window
  localparam int REF_CLK_PERIOD_NS = 25;
  localparam int SAMPLE_TIMEOUT_NS = 1000;
  localparam logic [5:0] SAMPLE_TIMEOUT_CYC = 6'(SAMPLE_TIMEOUT_NS / REF_CLK_PERIOD_NS);
  localparam logic [5:0] TIMER_ZERO = 6'h00;
  localparam logic [5:0] TIMER_ONE = 6'h01;

  // synchroniser lanes
  localparam int SYNC_WIDTH = 6;
  localparam int SYNC_SCLK = 0;
  localparam int SYNC_SEL_N = 1;
  localparam int SYNC_SDIO = 2;
  localparam int SYNC_PD_PIN = 3;
  localparam int SYNC_REF_PIN = 4;
  localparam int SYNC_SAMPLE = 5;

endpackage

// ****************************************************************
// two-stage level synchroniser
// ****************************************************************
module level_sync2 (
  input wire logic clk_i,                                        // sampling clock
  input wire logic reset_i,                                      // synchronous, active high
  input wire logic [cfg_port_pkg::SYNC_WIDTH-1:0] async_i,       // foreign levels
  output logic [cfg_port_pkg::SYNC_WIDTH-1:0] sync_o             // levels in clk_i domain
);

  typedef struct packed {
    logic [cfg_port_pkg::SYNC_WIDTH-1:0] meta;
    logic [cfg_port_pkg::SYNC_WIDTH-1:0] stable;
  } sync_state_type;

  sync_state_type st_reg;
  sync_state_type st_next;

  // first stage feeds only the second stage
  always_comb begin
    st_next.meta = async_i;
    st_next.stable = st_reg.meta;
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign sync_o = st_reg.stable;

endmodule

`default_nettype wire

// >>> serial_config_port.sv
// Behaviour
// R1 - bits are taken only while select is low; clock ignored while high
// R2 - data line sampled on each rising shift-clock edge while selected
// R3 - every 24th rising edge commits the assembled word to its register
// R4 - trailing partial word bits are dropped, no register changes
// R5 - many 24-bit words may follow within one select-low period
// R6 - host keeps shift clock at most 12 MHz; any slower rate works
// R7 - write word: read/write bit 0, three zeros, then 12-bit address
// R8 - eight data bits follow the address, each taken on a rising edge
// R9 - read/write bit 1 means read; registers stay unchanged
// R10 - on a read the addressed register content is driven after the address
// R11 - host samples read-back bits on shift-clock falling edges
// R12 - power-down takes effect only while the sampling clock runs
// R13 - defaults after power-up: bypass, 2-wire, two's complement, external ref
// R14 - works without serial access; power-down and reference also by pins
// R15 - words shift most significant bit first, read/write bit leading
// R16 - data line driven only in the last eight bit periods of a read
`default_nettype none

module serial_config_port (
  input wire logic REF_CLK_I,                 // 40 MHz system clock
  input wire logic RESET_I,                   // synchronous reset, active high
  input wire logic SERIAL_SELECT_N_I,         // serial select, active low
  input wire logic SCLK_I,                    // host shift clock
  input wire logic SDIO_I,                    // data line level seen at pin
  input wire logic POWERDOWN_SYNC_PIN_I,      // power-down pin, active high
  input wire logic REFERENCE_SELECT_PIN_I,    // high: external reference
  input wire logic SAMPLE_CLK_I,              // conversion sampling clock
  output logic SDIO_O,                        // read-back data
  output logic SDIO_OE_O,                     // high while driving data line
  output logic POWERDOWN_O,                   // effective global power-down
  output logic REF_INTERNAL_O,                // internal reference selected
  output logic [1:0] IF_SEL_O,                // output interface, 0 = 2-wire
  output logic OFFSET_BINARY_O,               // 0 = two's complement
  output logic DECIM_EN_O,                    // 0 = decimation bypass
  output logic AUTOZERO_EN_O,                 // auto-zero enable
  output logic CLK_SINGLE_ENDED_O,            // 0 = differential clock
  output logic INPUT_SINGLE_ENDED_O           // 0 = differential signal input
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic sclk_d;
    logic sample_d;
    logic [4:0] count;
    logic [23:0] shift;
    logic read_on;
    logic [7:0] rdata;
    logic oe;
    logic sdo;
    logic [5:0] sample_timer;
    logic sample_active;
    logic [cfg_port_pkg::REG_COUNT-1:0][7:0] regs;
    logic pd;
    logic ref_int;
    logic [1:0] if_sel;
    logic offset_bin;
    logic decim_en;
    logic autozero;
    logic clk_se;
    logic input_se;
  } port_state_type;

  port_state_type st_reg;
  port_state_type st_next;
  logic [cfg_port_pkg::SYNC_WIDTH-1:0] pins_async;
  logic [cfg_port_pkg::SYNC_WIDTH-1:0] pins;
  logic selected;
  logic rise;
  logic fall;
  logic commit_edge;
  logic [23:0] word_in;
  logic [11:0] addr_early;
  logic [11:0] addr_full;
  logic [cfg_port_pkg::REG_IDX_W-1:0] idx_early;
  logic [cfg_port_pkg::REG_IDX_W-1:0] idx_full;
  logic [7:0] reg_power;

  // ****************************************************************
  // pin synchronisation
  // ****************************************************************
  // every foreign pin, shift clock included, passes two flops
  always_comb begin
    pins_async = '0;
    pins_async[cfg_port_pkg::SYNC_SCLK] = SCLK_I;
    // select and reference lanes are inverted so an all-zero flop reads as idle after reset
    pins_async[cfg_port_pkg::SYNC_SEL_N] = ~SERIAL_SELECT_N_I;
    pins_async[cfg_port_pkg::SYNC_SDIO] = SDIO_I;
    pins_async[cfg_port_pkg::SYNC_PD_PIN] = POWERDOWN_SYNC_PIN_I;
    pins_async[cfg_port_pkg::SYNC_REF_PIN] = ~REFERENCE_SELECT_PIN_I;
    pins_async[cfg_port_pkg::SYNC_SAMPLE] = SAMPLE_CLK_I;
  end

  level_sync2 pin_sync (
    .clk_i(REF_CLK_I),
    .reset_i(RESET_I),
    .async_i(pins_async),
    .sync_o(pins)
  );

  // ****************************************************************
  // edge detection and word decode
  // ****************************************************************
  // R1 gate by select
  assign selected = pins[cfg_port_pkg::SYNC_SEL_N];
  // R6 edges found by sampling, any slower rate
  // R2 rising edge sample
  assign rise = selected & pins[cfg_port_pkg::SYNC_SCLK] & ~st_reg.sclk_d;
  assign fall = selected & ~pins[cfg_port_pkg::SYNC_SCLK] & st_reg.sclk_d;
  assign commit_edge = rise & (st_reg.count == cfg_port_pkg::CNT_LAST);
  // R15 msb first shift
  assign word_in = {st_reg.shift[22:0], pins[cfg_port_pkg::SYNC_SDIO]};
  assign addr_early = word_in[cfg_port_pkg::ADDR_HI_EARLY:cfg_port_pkg::ADDR_LO_EARLY];
  assign addr_full = word_in[cfg_port_pkg::ADDR_HI:cfg_port_pkg::ADDR_LO];
  assign idx_early = addr_early[cfg_port_pkg::REG_IDX_W-1:0];
  assign idx_full = addr_full[cfg_port_pkg::REG_IDX_W-1:0];
  assign reg_power = st_reg.regs[cfg_port_pkg::REG_POWER[cfg_port_pkg::REG_IDX_W-1:0]];

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    st_next = st_reg;
    st_next.sclk_d = pins[cfg_port_pkg::SYNC_SCLK];
    st_next.sample_d = pins[cfg_port_pkg::SYNC_SAMPLE];
    if (!selected) begin
      // R4 partial word dropped
      st_next.count = cfg_port_pkg::CNT_ZERO;
      st_next.read_on = 1'b0;
      // R16 released when deselected
      st_next.oe = 1'b0;
      st_next.sdo = 1'b0;
    end else if (rise) begin
      st_next.shift = word_in;
      // R10 fetch after address
      if (st_reg.count == cfg_port_pkg::CNT_ADDR_DONE) begin
        st_next.read_on = word_in[cfg_port_pkg::RW_POS_EARLY];
        st_next.rdata = (addr_early < cfg_port_pkg::REG_COUNT_ADDR) ? st_reg.regs[idx_early]
                                                                    : cfg_port_pkg::READ_EMPTY;
      end
      if (st_reg.count == cfg_port_pkg::CNT_LAST) begin
        // R5 next word starts
        st_next.count = cfg_port_pkg::CNT_ZERO;
        // R3 commit word
        // R9 read never writes
        if (!word_in[cfg_port_pkg::RW_POS] && addr_full < cfg_port_pkg::REG_COUNT_ADDR) begin
          if (addr_full == cfg_port_pkg::REG_SOFT_RESET) begin
            // self-clearing: the reset bit itself is never stored
            if (word_in[cfg_port_pkg::SOFT_RESET_BIT]) begin
              st_next.regs = '0;
            end
          end else begin
            // R8 data byte stored
            st_next.regs[idx_full] = word_in[cfg_port_pkg::DATA_HI:cfg_port_pkg::DATA_LO];
          end
        end
      end else begin
        st_next.count = st_reg.count + cfg_port_pkg::CNT_ONE;
      end
    end else if (fall) begin
      // R16 drive last eight periods
      // changing on the falling edge keeps a full period for the host
      if (st_reg.read_on && st_reg.count >= cfg_port_pkg::CNT_DATA_FIRST) begin
        st_next.oe = 1'b1;
        st_next.sdo = st_reg.rdata[7];
        st_next.rdata = {st_reg.rdata[6:0], 1'b0};
      end else begin
        st_next.oe = 1'b0;
        st_next.sdo = 1'b0;
        st_next.read_on = st_reg.read_on & (st_reg.count != cfg_port_pkg::CNT_ZERO);
      end
    end
    // sampling clock presence: any edge reloads the window
    if (pins[cfg_port_pkg::SYNC_SAMPLE] != st_reg.sample_d) begin
      st_next.sample_timer = cfg_port_pkg::SAMPLE_TIMEOUT_CYC;
    end else if (st_reg.sample_timer != cfg_port_pkg::TIMER_ZERO) begin
      st_next.sample_timer = st_reg.sample_timer - cfg_port_pkg::TIMER_ONE;
    end
    st_next.sample_active = st_reg.sample_timer != cfg_port_pkg::TIMER_ZERO;
    // R12 power-down needs sampling clock
    // R14 pin or register request
    if (st_reg.sample_active) begin
      st_next.pd = pins[cfg_port_pkg::SYNC_PD_PIN] | reg_power[cfg_port_pkg::PD_GLOBAL_BIT];
    end
    // R14 reference pin control
    st_next.ref_int = reg_power[cfg_port_pkg::REF_INTERNAL_BIT] | pins[cfg_port_pkg::SYNC_REF_PIN];
    st_next.if_sel = st_reg.regs[cfg_port_pkg::REG_INTERFACE[cfg_port_pkg::REG_IDX_W-1:0]]
                       [cfg_port_pkg::IF_SEL_HI:cfg_port_pkg::IF_SEL_LO];
    st_next.offset_bin = st_reg.regs[cfg_port_pkg::REG_FORMAT[cfg_port_pkg::REG_IDX_W-1:0]]
                           [cfg_port_pkg::OFFSET_BIN_BIT];
    st_next.decim_en = st_reg.regs[cfg_port_pkg::REG_DECIMATION[cfg_port_pkg::REG_IDX_W-1:0]]
                         [cfg_port_pkg::DECIM_EN_BIT];
    st_next.autozero = st_reg.regs[cfg_port_pkg::REG_AUTOZERO[cfg_port_pkg::REG_IDX_W-1:0]]
                         [cfg_port_pkg::AUTOZERO_BIT];
    st_next.clk_se = st_reg.regs[cfg_port_pkg::REG_INPUTS[cfg_port_pkg::REG_IDX_W-1:0]]
                       [cfg_port_pkg::CLK_SE_BIT];
    st_next.input_se = st_reg.regs[cfg_port_pkg::REG_INPUTS[cfg_port_pkg::REG_IDX_W-1:0]]
                         [cfg_port_pkg::INPUT_SE_BIT];
  end

  // R13 all-zero defaults
  always_ff @(posedge REF_CLK_I) begin
    if (RESET_I) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs straight from the state flops
  assign SDIO_O = st_reg.sdo;
  assign SDIO_OE_O = st_reg.oe;
  assign POWERDOWN_O = st_reg.pd;
  assign REF_INTERNAL_O = st_reg.ref_int;
  assign IF_SEL_O = st_reg.if_sel;
  assign OFFSET_BINARY_O = st_reg.offset_bin;
  assign DECIM_EN_O = st_reg.decim_en;
  assign AUTOZERO_EN_O = st_reg.autozero;
  assign CLK_SINGLE_ENDED_O = st_reg.clk_se;
  assign INPUT_SINGLE_ENDED_O = st_reg.input_se;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge REF_CLK_I);
  endclocking
  default disable iff (RESET_I);

  AST_DESELECT_IDLE: assert property (!selected |=> st_reg.count == cfg_port_pkg::CNT_ZERO && !st_reg.oe) // R1
    else $error("port not idle while deselected");
  AST_COUNT_STEP: assert property ((rise && st_reg.count != cfg_port_pkg::CNT_LAST) |=>
      st_reg.count == $past(st_reg.count) + cfg_port_pkg::CNT_ONE) // R2
    else $error("bit count did not advance on rising edge");
  AST_COMMIT_ONLY_24TH: assert property ($changed(st_reg.regs) |-> $past(commit_edge)) // R3
    else $error("register changed outside a 24th edge");
  AST_PARTIAL_DISCARD: assert property ((!selected && st_reg.count != cfg_port_pkg::CNT_ZERO) |=>
      $stable(st_reg.regs)) // R4
    else $error("partial word altered a register");
  AST_NEXT_WORD: assert property (commit_edge |=> st_reg.count == cfg_port_pkg::CNT_ZERO) // R5
    else $error("count not restarted after a full word");
  AST_READ_NO_WRITE: assert property ((commit_edge && word_in[cfg_port_pkg::RW_POS]) |=> $stable(st_reg.regs)) // R9
    else $error("read access modified a register");
  AST_READ_FIRST_BIT: assert property ((fall && st_reg.read_on && st_reg.count == cfg_port_pkg::CNT_DATA_FIRST) |=>
      st_reg.oe && st_reg.sdo == $past(st_reg.rdata[7])) // R10
    else $error("first read bit not driven");
  AST_DRIVE_WINDOW: assert property (st_reg.oe |-> $past(selected) && st_reg.read_on &&
      (st_reg.count >= cfg_port_pkg::CNT_DATA_FIRST || st_reg.count == cfg_port_pkg::CNT_ZERO)) // R16
    else $error("data line driven outside read window");
  AST_PD_NEEDS_CLOCK: assert property ($changed(st_reg.pd) |-> $past(st_reg.sample_active)) // R12
    else $error("power-down changed without sampling clock");
  AST_DEFAULTS: assert property ($fell(RESET_I) |-> st_reg.regs == '0 && !st_reg.pd && !st_reg.oe) // R13
    else $error("defaults not restored by reset");

  COV_WRITE: cover property (commit_edge && !word_in[cfg_port_pkg::RW_POS]);
  COV_READ: cover property (st_reg.oe ##1 !st_reg.oe);
  COV_PARTIAL: cover property (st_reg.count == cfg_port_pkg::CNT_DATA_FIRST ##1 !selected);
  COV_PD: cover property ($rose(st_reg.pd));

endmodule

`default_nettype wire

// >>> cfg_host_model.sv
`default_nettype none

// ****************************************************************
// host controller driving the serial configuration bus
// ****************************************************************
module cfg_host_model (
  input wire logic clk_i,       // bench reference clock
  input wire logic sdio_i,      // device read-back bit
  input wire logic sdio_oe_i,   // device drive enable
  output var logic sel_n_o,     // serial select, active low
  output var logic sclk_o,      // shift clock, low between words
  output wire logic line_o      // resolved data-line level
);
  timeunit 1ns;
  timeprecision 1ps;

  logic bit_reg = 1'b0;
  logic drv = 1'b0;
  logic last_line = 1'b0;
  int hi_cyc = 4;               // shift-clock high time less one, in bench cycles; period stays 9

  initial begin
    sel_n_o = 1'b1;
    sclk_o = 1'b0;
  end

  // a released line shows the inverse of its last level, so a stale bit never passes
  assign line_o = sdio_oe_i ? sdio_i : (drv ? bit_reg : ~last_line);

  always @(posedge clk_i) begin
    last_line <= line_o;
  end

  task automatic wait_cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  // select change, then a settling gap before any clock edge
  task automatic frame(input logic low);
    @(negedge clk_i);
    sel_n_o = ~low;
    wait_cyc(6);
  endtask

  // 225 ns period, words may follow in one frame
  task automatic shift(input logic [23:0] word, input int nbits, output logic [7:0] rd);
    rd = 8'h00;
    for (int k = 1; k <= nbits; k++) begin
      @(negedge clk_i);
      // read-back bit taken at the falling edge
      if (k > 17) rd = {rd[6:0], line_o};
      sclk_o = 1'b0;
      bit_reg = word[24 - k];
      drv = ~(word[23] && k > 16);
      wait_cyc(8 - hi_cyc);
      sclk_o = 1'b1;
      wait_cyc(hi_cyc);
    end
    @(negedge clk_i);
    if (nbits == 24) rd = {rd[6:0], line_o};
    sclk_o = 1'b0;
    wait_cyc(3);
    drv = 1'b0;
  endtask
endmodule

`default_nettype wire

// >>> serial_config_port_tb.sv
`default_nettype none

`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin bad_count++; \
  $display("ERROR t=%0t got %h exp %h", $time, (a), (b)); end end

// ****************************************************************
// self-checking bench of the serial configuration port
// ****************************************************************
module serial_config_port_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk = 1'b0;
  logic rst = 1'b1;
  logic pd_pin = 1'b0;
  logic ref_pin = 1'b1;
  logic samp = 1'b0;
  logic samp_run = 1'b1;
  wire logic sel_n;
  wire logic sclk;
  wire logic line;
  wire logic sdo, sdo_oe, pd, ref_int, ofs, dec, az, cse, ise;
  wire logic [1:0] ifs;
  logic [7:0] rd;
  int bad_count = 0;
  int comparisons = 0;
  int cycles = 0;

  always #12.5 clk = ~clk;

  // sampling clock runs unless a scenario stops it
  always @(negedge clk) begin
    if (samp_run) samp <= ~samp;
  end

  // hang guard, far above the expected run length
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      bad_count++;
      give_verdict();
    end
  end

  serial_config_port serial_config_port_i (
    .REF_CLK_I(clk),
    .RESET_I(rst),
    .SERIAL_SELECT_N_I(sel_n),
    .SCLK_I(sclk),
    .SDIO_I(line),
    .POWERDOWN_SYNC_PIN_I(pd_pin),
    .REFERENCE_SELECT_PIN_I(ref_pin),
    .SAMPLE_CLK_I(samp),
    .SDIO_O(sdo),
    .SDIO_OE_O(sdo_oe),
    .POWERDOWN_O(pd),
    .REF_INTERNAL_O(ref_int),
    .IF_SEL_O(ifs),
    .OFFSET_BINARY_O(ofs),
    .DECIM_EN_O(dec),
    .AUTOZERO_EN_O(az),
    .CLK_SINGLE_ENDED_O(cse),
    .INPUT_SINGLE_ENDED_O(ise)
  );

  cfg_host_model cfg_host_model_i (
    .clk_i(clk),
    .sdio_i(sdo),
    .sdio_oe_i(sdo_oe),
    .sel_n_o(sel_n),
    .sclk_o(sclk),
    .line_o(line)
  );

  task automatic give_verdict();
    $display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic wr(input logic [11:0] addr, input logic [7:0] data);
    cfg_host_model_i.frame(1'b1);
    cfg_host_model_i.shift({4'h0, addr, data}, 24, rd);
    cfg_host_model_i.frame(1'b0);
  endtask

  task automatic rdreg(input logic [11:0] addr);
    cfg_host_model_i.frame(1'b1);
    cfg_host_model_i.shift({4'h8, addr, 8'h00}, 24, rd);
    cfg_host_model_i.frame(1'b0);
  endtask

  task automatic t_defaults();
    `CHK({pd, ref_int, ifs, ofs, dec, az, cse, ise}, 9'h000)
    `CHK(sdo_oe, 1'b0)
  endtask

  // write then read back; a read with zero data must not clear
  task automatic t_write_read();
    wr(cfg_port_pkg::REG_FORMAT, 8'h01);
    `CHK(ofs, 1'b1)
    wr(cfg_port_pkg::REG_INTERFACE, 8'h02);
    `CHK(ifs, 2'h2)
    rdreg(cfg_port_pkg::REG_FORMAT);
    `CHK(rd, 8'h01)
    `CHK(ofs, 1'b1)
    // a write beyond the map must not alias onto the format register
    wr(12'h00B, 8'h00);
    `CHK(ofs, 1'b1)
    rdreg(cfg_port_pkg::REG_INTERFACE);
    `CHK(rd, 8'h02)
    `CHK(sdo_oe, 1'b0)
    // low bits alias the interface register, which holds non-zero data
    rdreg(12'h00A);
    `CHK(rd, cfg_port_pkg::READ_EMPTY)
  endtask

  // two words and a partial tail in one frame, then a short frame
  task automatic t_multi();
    cfg_host_model_i.hi_cyc = 5;
    cfg_host_model_i.frame(1'b1);
    cfg_host_model_i.shift({4'h0, cfg_port_pkg::REG_DECIMATION, 8'h01}, 24, rd);
    cfg_host_model_i.shift({4'h0, cfg_port_pkg::REG_AUTOZERO, 8'h01}, 24, rd);
    cfg_host_model_i.shift({4'h0, cfg_port_pkg::REG_INPUTS, 8'h03}, 10, rd);
    cfg_host_model_i.frame(1'b0);
    `CHK({dec, az}, 2'h3)
    cfg_host_model_i.frame(1'b1);
    cfg_host_model_i.shift({4'h0, cfg_port_pkg::REG_INPUTS, 8'h03}, 23, rd);
    cfg_host_model_i.frame(1'b0);
    `CHK({cse, ise}, 2'h0)
    cfg_host_model_i.hi_cyc = 4;
    wr(cfg_port_pkg::REG_INPUTS, 8'h03);
    `CHK({cse, ise}, 2'h3)
  endtask

  // a whole word clocked while not selected is ignored
  task automatic t_unselected();
    cfg_host_model_i.shift({4'h0, cfg_port_pkg::REG_INTERFACE, 8'h01}, 24, rd);
    cfg_host_model_i.wait_cyc(8);
    `CHK(ifs, 2'h2)
  endtask

  // pin power-down needs the sampling clock; then serial power-down and soft reset
  task automatic t_power();
    @(negedge clk);
    ref_pin = 1'b0;
    cfg_host_model_i.wait_cyc(8);
    `CHK(ref_int, 1'b1)
    ref_pin = 1'b1;
    samp_run = 1'b0;
    cfg_host_model_i.wait_cyc(60);
    pd_pin = 1'b1;
    cfg_host_model_i.wait_cyc(20);
    `CHK(pd, 1'b0)
    samp_run = 1'b1;
    cfg_host_model_i.wait_cyc(20);
    `CHK(pd, 1'b1)
    pd_pin = 1'b0;
    cfg_host_model_i.wait_cyc(20);
    `CHK(pd, 1'b0)
    wr(cfg_port_pkg::REG_POWER, 8'h03);
    `CHK({pd, ref_int}, 2'h3)
    wr(cfg_port_pkg::REG_SOFT_RESET, 8'h01);
    `CHK({pd, ref_int, ifs, ofs, dec, az, cse, ise}, 9'h000)
  endtask

  initial begin
    repeat (6) @(negedge clk);
    rst = 1'b0;
    cfg_host_model_i.wait_cyc(4);
    t_defaults();
    t_write_read();
    t_multi();
    t_unselected();
    t_power();
    give_verdict();
  end
endmodule

`undef CHK

`default_nettype wire
